/* File: shared/xtcal_pkg.sv */
// Purpose: Constants for crosstalk calibration, scaling and readback control
// Assumes: 24-bit registers reached by the serial control port at byte addresses
// Notes:   Every offset, field position, reset value and count lives here
//
// Operation
// - Filter time constant is 2^field frames; field resets to 8.
// - Programmed light crosstalk values are multiplied by 2^light scale field.
// - Programmed electrical crosstalk I and Q are multiplied by 2^electrical scale.
// - Setting the light calibrate bit starts light crosstalk measurement.
// - Electrical calibrate bit starts measurement; host sets, waits, then clears.
// - Readback select: 0 electrical, 1 light, 2 raw I/Q, 3 frame count.
// - Light source bit: 0 calibrated, 1 programmed; resets to 1.
// - Light measurement: 0 direct sampling, 1 filtered; resets filtered.
// - Electrical source bit: 0 calibrated, 1 programmed; resets to 0.
// - Electrical measurement: 0 direct sampling, 1 filtered; resets filtered.
// - Auto gain active while disable bit is 0, inactive while 1.
// - Auto gain disabled applies forced code, scale 2^(6 - code).
// - Forced gain code applies during any calibration, even with auto gain on.
// - Temperature coefficient ch1 high bits 11:4 sit in register bits 23:16.
// - Light in-phase value ch0 low sits in bits 15:0 of its register.
// - Coefficient bits 3:0 sit in bits 23:20 next register; 19:16 read zero.
// - Light quadrature value ch0 low sits in bits 15:0 of next register.

package xtcal_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 24;
  localparam int SAMPLE_W = 16;
  localparam int SCALED_W = 24;
  localparam int FRAC_W   = 15;

  localparam logic [7:0]  OFS_CTRL    = 8'h2e;
  localparam logic [7:0]  OFS_COEF_HI = 8'h2f;
  localparam logic [7:0]  OFS_COEF_LO = 8'h30;

  localparam logic [23:0] CTRL_RESET  = 24'h8001a0;
  localparam logic [23:0] COEF_RESET  = 24'h000000;

  localparam int TC_MSB     = 23;
  localparam int TC_LSB     = 20;
  localparam int LSCALE_MSB = 19;
  localparam int LSCALE_LSB = 17;
  localparam int ESCALE_MSB = 16;
  localparam int ESCALE_LSB = 14;
  localparam int ZERO_BIT   = 13;
  localparam int LCAL_BIT   = 12;
  localparam int SEL_MSB    = 11;
  localparam int SEL_LSB    = 9;
  localparam int LPROG_BIT  = 8;
  localparam int LFILT_BIT  = 7;
  localparam int EPROG_BIT  = 6;
  localparam int EFILT_BIT  = 5;
  localparam int ECAL_BIT   = 4;
  localparam int AGDIS_BIT  = 3;
  localparam int FGAIN_MSB  = 2;
  localparam int FGAIN_LSB  = 0;

  localparam int COEF_HI_MSB = 23;
  localparam int COEF_HI_LSB = 16;
  localparam int COEF_LO_MSB = 23;
  localparam int COEF_LO_LSB = 20;
  localparam int VAL_MSB     = 15;
  localparam int VAL_LSB     = 0;

  localparam logic [2:0] SEL_ELEC  = 3'h0;
  localparam logic [2:0] SEL_LIGHT = 3'h1;
  localparam logic [2:0] SEL_RAW   = 3'h2;
  localparam logic [2:0] SEL_FRAME = 3'h3;

  localparam logic [3:0] GAIN_BASE = 4'h6;

endpackage

/* File: logic/xtcal_leak_filter.sv */
// Purpose: One crosstalk component measurement: direct sample or recursive average
// Assumes: frame_done is a one-cycle pulse on core_clk with sample valid alongside
// Notes:   Result holds whenever calibrate is low
`timescale 1ns/100ps

module xtcal_leak_filter #(
  parameter int SAMPLE_W = 16,
  parameter int FRAC_W   = 15
) (
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  input  wire logic                       frame_done,
  input  wire logic                       calibrate,
  input  wire logic                       use_filter,
  input  wire logic [3:0]                 tc_exp,
  input  wire logic signed [SAMPLE_W-1:0] sample,
  output logic signed [SAMPLE_W-1:0]      result
);

  localparam int ACC_W = SAMPLE_W + FRAC_W;

  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;
  logic                    first_q;
  logic                    first_d;
  logic signed [ACC_W-1:0] target;
  logic signed [ACC_W:0]   diff;
  logic signed [ACC_W:0]   step;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    target  = {sample, {FRAC_W{1'b0}}};
    diff    = {target[ACC_W-1], target} - {acc_q[ACC_W-1], acc_q};
    step    = diff >>> tc_exp;
    acc_d   = acc_q;
    first_d = first_q;
    if (!calibrate) begin
      first_d = 1'b1;
    end else if (frame_done) begin
      first_d = 1'b0;
      // First frame seeds the average so settling starts from a real sample
      if (first_q || !use_filter) begin
        acc_d = target;
      end else begin
        acc_d = acc_q + step[ACC_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_q   <= '0;
      first_q <= 1'b1;
    end else begin
      acc_q   <= acc_d;
      first_q <= first_d;
    end
  end

  assign result = acc_q[ACC_W-1:FRAC_W];

  ////////////////////////////////////////////////////////////////////////////
  property p_freeze;
    @(posedge core_clk) disable iff (srst)
      !calibrate |=> acc_q == $past(acc_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("result moved while idle");

  property p_direct;
    @(posedge core_clk) disable iff (srst)
      (calibrate && frame_done && !use_filter) |=> result == $past(sample);
  endproperty
  a_direct: assert property (p_direct) else $error("direct sample not taken");

  property p_per_frame;
    @(posedge core_clk) disable iff (srst)
      (calibrate && !frame_done) |=> $stable(acc_q);
  endproperty
  a_per_frame: assert property (p_per_frame) else $error("update outside frame");

endmodule

/* File: logic/xtcal_top.sv */
// Purpose: Crosstalk calibration, crosstalk scaling, readback mux and gain control
// Assumes: Register port, frame pulse and samples all on core_clk from on-chip logic
// Notes:   Reads answer one cycle after reg_rd_en; unmapped reads return zero
`timescale 1ns/100ps

module xtcal_top #(
  parameter int SAMPLE_W = xtcal_pkg::SAMPLE_W,
  parameter int SCALED_W = xtcal_pkg::SCALED_W
) (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        reg_wr_en,
  input  wire logic                        reg_rd_en,
  input  wire logic [xtcal_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [xtcal_pkg::DATA_W-1:0] reg_wdata,
  output logic [xtcal_pkg::DATA_W-1:0]      reg_rdata,
  output logic                             reg_rvalid,
  input  wire logic                        frame_done,
  input  wire logic signed [SAMPLE_W-1:0]  raw_i,
  input  wire logic signed [SAMPLE_W-1:0]  raw_q,
  input  wire logic signed [SAMPLE_W-1:0]  elec_leak_prog_i,
  input  wire logic signed [SAMPLE_W-1:0]  elec_leak_prog_q,
  input  wire logic [2:0]                  auto_gain_code,
  output logic [2:0]                       applied_gain_code,
  output logic signed [3:0]                gain_exp,
  output logic                             auto_gain_active,
  output logic                             calib_active,
  output logic signed [SCALED_W-1:0]       elec_leak_i,
  output logic signed [SCALED_W-1:0]       elec_leak_q,
  output logic signed [SCALED_W-1:0]       light_leak_i,
  output logic signed [SCALED_W-1:0]       light_leak_q,
  output logic [11:0]                      phase_temp_coef_ch1_high,
  output logic [SAMPLE_W-1:0]              inphase_readback,
  output logic [SAMPLE_W-1:0]              quad_readback
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [23:0] ctrl_q;
  logic [23:0] ctrl_d;
  logic [23:0] coef_hi_q;
  logic [23:0] coef_hi_d;
  logic [23:0] coef_lo_q;
  logic [23:0] coef_lo_d;
  logic [23:0] rdata_q;
  logic [23:0] rdata_d;
  logic        rvalid_q;

  always_comb begin
    ctrl_d    = ctrl_q;
    coef_hi_d = coef_hi_q;
    coef_lo_d = coef_lo_q;
    rdata_d   = rdata_q;
    if (reg_wr_en) begin
      unique case (reg_addr)
        xtcal_pkg::OFS_CTRL: begin
          ctrl_d = reg_wdata;
          ctrl_d[xtcal_pkg::ZERO_BIT] = 1'b0;
        end
        xtcal_pkg::OFS_COEF_HI: begin
          coef_hi_d = reg_wdata;
        end
        xtcal_pkg::OFS_COEF_LO: begin
          coef_lo_d = reg_wdata;
          coef_lo_d[xtcal_pkg::COEF_LO_LSB-1:xtcal_pkg::SAMPLE_W] = '0;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        xtcal_pkg::OFS_CTRL:    rdata_d = ctrl_q;
        xtcal_pkg::OFS_COEF_HI: rdata_d = coef_hi_q;
        xtcal_pkg::OFS_COEF_LO: rdata_d = coef_lo_q;
        default:                rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q    <= xtcal_pkg::CTRL_RESET;
      coef_hi_q <= xtcal_pkg::COEF_RESET;
      coef_lo_q <= xtcal_pkg::COEF_RESET;
      rdata_q   <= '0;
      rvalid_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      coef_hi_q <= coef_hi_d;
      coef_lo_q <= coef_lo_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= reg_rd_en;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control field views
  logic [3:0] tc_exp;
  logic [2:0] light_scale;
  logic [2:0] elec_scale;
  logic [2:0] rb_sel;
  logic [2:0] forced_gain_code;
  logic       light_leak_calibrate;
  logic       elec_leak_calibrate;
  logic       light_leak_use_programmed;
  logic       light_leak_use_filter;
  logic       elec_leak_use_programmed;
  logic       elec_leak_use_filter;
  logic       auto_gain_disable;

  assign tc_exp                    = ctrl_q[xtcal_pkg::TC_MSB:xtcal_pkg::TC_LSB];
  assign light_scale               = ctrl_q[xtcal_pkg::LSCALE_MSB:xtcal_pkg::LSCALE_LSB];
  assign elec_scale                = ctrl_q[xtcal_pkg::ESCALE_MSB:xtcal_pkg::ESCALE_LSB];
  assign rb_sel                    = ctrl_q[xtcal_pkg::SEL_MSB:xtcal_pkg::SEL_LSB];
  assign forced_gain_code          = ctrl_q[xtcal_pkg::FGAIN_MSB:xtcal_pkg::FGAIN_LSB];
  assign light_leak_calibrate      = ctrl_q[xtcal_pkg::LCAL_BIT];
  assign elec_leak_calibrate       = ctrl_q[xtcal_pkg::ECAL_BIT];
  assign light_leak_use_programmed = ctrl_q[xtcal_pkg::LPROG_BIT];
  assign light_leak_use_filter     = ctrl_q[xtcal_pkg::LFILT_BIT];
  assign elec_leak_use_programmed  = ctrl_q[xtcal_pkg::EPROG_BIT];
  assign elec_leak_use_filter      = ctrl_q[xtcal_pkg::EFILT_BIT];
  assign auto_gain_disable         = ctrl_q[xtcal_pkg::AGDIS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Measurements: index 0 elec I, 1 elec Q, 2 light I, 3 light Q
  logic signed [SAMPLE_W-1:0] meas [4];

  for (genvar g = 0; g < 4; g++) begin : g_meas
    xtcal_leak_filter #(
      .SAMPLE_W (SAMPLE_W),
      .FRAC_W   (xtcal_pkg::FRAC_W)
    ) u_filt (
      .core_clk   (core_clk),
      .srst       (srst),
      .frame_done (frame_done),
      .calibrate  ((g < 2) ? elec_leak_calibrate : light_leak_calibrate),
      .use_filter ((g < 2) ? elec_leak_use_filter : light_leak_use_filter),
      .tc_exp     (tc_exp),
      .sample     ((g % 2 == 0) ? raw_i : raw_q),
      .result     (meas[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied crosstalk: programmed values scaled, calibrated values pass as measured
  logic signed [SCALED_W-1:0] elec_i_q;
  logic signed [SCALED_W-1:0] elec_i_d;
  logic signed [SCALED_W-1:0] elec_q_q;
  logic signed [SCALED_W-1:0] elec_q_d;
  logic signed [SCALED_W-1:0] light_i_q;
  logic signed [SCALED_W-1:0] light_i_d;
  logic signed [SCALED_W-1:0] light_q_q;
  logic signed [SCALED_W-1:0] light_q_d;
  logic signed [SAMPLE_W-1:0] light_prog_i;
  logic signed [SAMPLE_W-1:0] light_prog_q;

  assign light_prog_i = coef_hi_q[xtcal_pkg::VAL_MSB:xtcal_pkg::VAL_LSB];
  assign light_prog_q = coef_lo_q[xtcal_pkg::VAL_MSB:xtcal_pkg::VAL_LSB];

  always_comb begin
    if (elec_leak_use_programmed) begin
      elec_i_d = SCALED_W'(elec_leak_prog_i) <<< elec_scale;
      elec_q_d = SCALED_W'(elec_leak_prog_q) <<< elec_scale;
    end else begin
      elec_i_d = SCALED_W'(meas[0]);
      elec_q_d = SCALED_W'(meas[1]);
    end
    if (light_leak_use_programmed) begin
      light_i_d = SCALED_W'(light_prog_i) <<< light_scale;
      light_q_d = SCALED_W'(light_prog_q) <<< light_scale;
    end else begin
      light_i_d = SCALED_W'(meas[2]);
      light_q_d = SCALED_W'(meas[3]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      elec_i_q  <= '0;
      elec_q_q  <= '0;
      light_i_q <= '0;
      light_q_q <= '0;
    end else begin
      elec_i_q  <= elec_i_d;
      elec_q_q  <= elec_q_d;
      light_i_q <= light_i_d;
      light_q_q <= light_q_d;
    end
  end

  assign elec_leak_i  = elec_i_q;
  assign elec_leak_q  = elec_q_q;
  assign light_leak_i = light_i_q;
  assign light_leak_q = light_q_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gain, frame counter, readback, coefficient
  logic [2:0]          gain_code_q;
  logic [2:0]          gain_code_d;
  logic signed [3:0]   gain_exp_q;
  logic signed [3:0]   gain_exp_d;
  logic                auto_q;
  logic                auto_d;
  logic                cal_q;
  logic                cal_d;
  logic [15:0]         frame_cnt_q;
  logic [15:0]         frame_cnt_d;
  logic [SAMPLE_W-1:0] rb_i_q;
  logic [SAMPLE_W-1:0] rb_i_d;
  logic [SAMPLE_W-1:0] rb_q_q;
  logic [SAMPLE_W-1:0] rb_q_d;
  logic [11:0]         coef_q;
  logic [11:0]         coef_d;

  always_comb begin
    cal_d  = light_leak_calibrate | elec_leak_calibrate;
    // Calibration must see a fixed gain or the average would mix scales
    auto_d = !auto_gain_disable && !cal_d;
    gain_code_d = auto_d ? auto_gain_code : forced_gain_code;
    gain_exp_d  = $signed(xtcal_pkg::GAIN_BASE - {1'b0, gain_code_d});
    frame_cnt_d = frame_done ? frame_cnt_q + 16'h0001 : frame_cnt_q;
    coef_d = {coef_hi_q[xtcal_pkg::COEF_HI_MSB:xtcal_pkg::COEF_HI_LSB],
              coef_lo_q[xtcal_pkg::COEF_LO_MSB:xtcal_pkg::COEF_LO_LSB]};
    unique case (rb_sel)
      xtcal_pkg::SEL_ELEC: begin
        rb_i_d = meas[0];
        rb_q_d = meas[1];
      end
      xtcal_pkg::SEL_LIGHT: begin
        rb_i_d = meas[2];
        rb_q_d = meas[3];
      end
      xtcal_pkg::SEL_RAW: begin
        rb_i_d = raw_i;
        rb_q_d = raw_q;
      end
      xtcal_pkg::SEL_FRAME: begin
        rb_i_d = frame_cnt_q;
        rb_q_d = '0;
      end
      // Invalid codes read as zero rather than stale data
      default: begin
        rb_i_d = '0;
        rb_q_d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gain_code_q <= 3'h0;
      gain_exp_q  <= 4'sh0;
      auto_q      <= 1'b0;
      cal_q       <= 1'b0;
      frame_cnt_q <= 16'h0000;
      rb_i_q      <= '0;
      rb_q_q      <= '0;
      coef_q      <= 12'h000;
    end else begin
      gain_code_q <= gain_code_d;
      gain_exp_q  <= gain_exp_d;
      auto_q      <= auto_d;
      cal_q       <= cal_d;
      frame_cnt_q <= frame_cnt_d;
      rb_i_q      <= rb_i_d;
      rb_q_q      <= rb_q_d;
      coef_q      <= coef_d;
    end
  end

  assign applied_gain_code        = gain_code_q;
  assign gain_exp                 = gain_exp_q;
  assign auto_gain_active         = auto_q;
  assign calib_active             = cal_q;
  assign phase_temp_coef_ch1_high = coef_q;
  assign inphase_readback         = rb_i_q;
  assign quad_readback            = rb_q_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_forced_in_cal;
    @(posedge core_clk) disable iff (srst)
      (light_leak_calibrate || elec_leak_calibrate)
        |=> gain_code_q == $past(forced_gain_code) && !auto_q;
  endproperty
  a_forced_in_cal: assert property (p_forced_in_cal) else $error("gain not forced");

  property p_auto_gain;
    @(posedge core_clk) disable iff (srst)
      (!auto_gain_disable && !light_leak_calibrate && !elec_leak_calibrate)
        |=> auto_q && gain_code_q == $past(auto_gain_code);
  endproperty
  a_auto_gain: assert property (p_auto_gain) else $error("auto gain not applied");

  property p_gain_exp;
    @(posedge core_clk) disable iff (srst)
      (auto_gain_disable && forced_gain_code == 3'h2) |=> gain_exp_q == 4'sh4;
  endproperty
  a_gain_exp: assert property (p_gain_exp) else $error("gain exponent wrong");

  property p_frame_rb;
    @(posedge core_clk) disable iff (srst)
      (rb_sel == xtcal_pkg::SEL_FRAME && frame_done) |=> ##1
        rb_i_q == $past(frame_cnt_q);
  endproperty
  a_frame_rb: assert property (p_frame_rb) else $error("frame count readback wrong");

  property p_light_scale;
    @(posedge core_clk) disable iff (srst)
      (light_leak_use_programmed && light_scale == 3'h3)
        |=> light_i_q == (SCALED_W'($past(light_prog_i)) <<< 3);
  endproperty
  a_light_scale: assert property (p_light_scale) else $error("light scale wrong");

  property p_elec_scale;
    @(posedge core_clk) disable iff (srst)
      (elec_leak_use_programmed && elec_scale == 3'h1)
        |=> elec_q_q == (SCALED_W'($past(elec_leak_prog_q)) <<< 1);
  endproperty
  a_elec_scale: assert property (p_elec_scale) else $error("electrical scale wrong");

  property p_rsvd_zero;
    @(posedge core_clk) disable iff (srst)
      (reg_rd_en && reg_addr == xtcal_pkg::OFS_COEF_LO) |=> reg_rvalid && reg_rdata[19:16] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  property p_coef;
    @(posedge core_clk) disable iff (srst)
      (reg_wr_en && reg_addr == xtcal_pkg::OFS_COEF_HI) |=> ##1
        phase_temp_coef_ch1_high[11:4] == $past(reg_wdata[23:16], 2);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient high bits wrong");

endmodule

/* File: verif/xtcal_seq_model.sv */
// Purpose: Frame sequencer stand-in, end-of-frame pulse with I/Q samples
// Assumes: Called from the bench; changes only on falling core_clk edges
// Notes:   Samples valid with the pulse only; inverted between frames
`timescale 1ns/100ps

module xtcal_seq_model (
  input  wire logic core_clk,
  output logic      frame_done,
  output logic [15:0] raw_i,
  output logic [15:0] raw_q
);
  int frames = 0;

  initial begin
    frame_done = 1'b0;
    raw_i      = 16'h0000;
    raw_q      = 16'h0000;
  end

  // One frame: one-cycle pulse carrying the given I/Q samples
  task automatic frame(input logic [15:0] i, input logic [15:0] q);
    @(negedge core_clk);
    frame_done = 1'b1;
    raw_i      = i;
    raw_q      = q;
    frames++;
    @(negedge core_clk);
    frame_done = 1'b0;
    // Stale lines must never pass for data
    raw_i      = ~i;
    raw_q      = ~q;
  endtask
endmodule

/* File: verif/crosstalk_calib_scale_control_tb.sv */
// Purpose: Register, calibration, scaling, readback and gain checks
// Assumes: Strobes driven on falling edges; outputs settle within 3 cycles
// Notes:   Host waits are 5 time constants; filter shown mid-calibration
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", nm, e, g); end end

module crosstalk_calib_scale_control_tb;
  logic        core_clk;
  logic        srst;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_addr;
  logic [23:0] reg_wdata;
  logic [23:0] reg_rdata;
  logic        reg_rvalid;
  logic        frame_done;
  logic [15:0] raw_i;
  logic [15:0] raw_q;
  logic [15:0] prog_i;
  logic [15:0] prog_q;
  logic [2:0]  auto_gain_code;
  logic [2:0]  applied_gain_code;
  logic [3:0]  gain_exp;
  logic        auto_gain_active;
  logic        calib_active;
  logic [23:0] elec_leak_i;
  logic [23:0] elec_leak_q;
  logic [23:0] light_leak_i;
  logic [23:0] light_leak_q;
  logic [11:0] coef;
  logic [15:0] inphase_readback;
  logic [15:0] quad_readback;
  int          errors = 0;
  int          num_checks = 0;

  xtcal_seq_model seq (
    .core_clk   (core_clk),
    .frame_done (frame_done),
    .raw_i      (raw_i),
    .raw_q      (raw_q)
  );

  xtcal_top dut (
    .core_clk                 (core_clk),
    .srst                     (srst),
    .reg_wr_en                (reg_wr_en),
    .reg_rd_en                (reg_rd_en),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .reg_rvalid               (reg_rvalid),
    .frame_done               (frame_done),
    .raw_i                    (raw_i),
    .raw_q                    (raw_q),
    .elec_leak_prog_i         (prog_i),
    .elec_leak_prog_q         (prog_q),
    .auto_gain_code           (auto_gain_code),
    .applied_gain_code        (applied_gain_code),
    .gain_exp                 (gain_exp),
    .auto_gain_active         (auto_gain_active),
    .calib_active             (calib_active),
    .elec_leak_i              (elec_leak_i),
    .elec_leak_q              (elec_leak_q),
    .light_leak_i             (light_leak_i),
    .light_leak_q             (light_leak_q),
    .phase_temp_coef_ch1_high (coef),
    .inphase_readback         (inphase_readback),
    .quad_readback            (quad_readback)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(negedge core_clk);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    `CHK("reg_rvalid", 1'b1, reg_rvalid)
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic rb(input logic [15:0] ei, input logic [15:0] eq);
    repeat (3) @(negedge core_clk);
    `CHK("inphase_readback", ei, inphase_readback)
    `CHK("quad_readback", eq, quad_readback)
  endtask

  initial begin
    #50000;
    errors++;
    give_verdict();
  end

  initial begin
    srst           = 1'b1;
    reg_wr_en      = 1'b0;
    reg_rd_en      = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 24'h000000;
    prog_i         = 16'hfffd;
    prog_q         = 16'h0100;
    auto_gain_code = 3'h5;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    rd(8'h2e, 24'h8001a0);
    rd(8'h2f, 24'h000000);
    rd(8'h30, 24'h000000);
    wr(8'h31, 24'hffffff);
    rd(8'h31, 24'h000000);
    wr(8'h2e, 24'h8021a0);
    rd(8'h2e, 24'h8001a0);
    wr(8'h2f, 24'hab1234);
    wr(8'h30, 24'hcf5678);
    rd(8'h30, 24'hc05678);
    `CHK("coef", 12'habc, coef)
    `CHK("light_leak_i", 24'h001234, light_leak_i)
    `CHK("agc_active", 1'b1, auto_gain_active)
    `CHK("applied_gain", 3'h5, applied_gain_code)
    wr(8'h2e, 24'h8641e0);
    `CHK("light_leak_i", 24'h0091a0, light_leak_i)
    `CHK("light_leak_q", 24'h02b3c0, light_leak_q)
    `CHK("elec_leak_i", 24'hfffffa, elec_leak_i)
    `CHK("elec_leak_q", 24'h000200, elec_leak_q)
    wr(8'h2e, 24'h8001aa);
    `CHK("applied_gain", 3'h2, applied_gain_code)
    `CHK("gain_exp", 4'h4, gain_exp)
    `CHK("agc_active", 1'b0, auto_gain_active)
    // Electrical calibration, direct sampling, forced code 3 with auto gain on
    // Time constant 1 frame so five frames meet the host's settling wait
    wr(8'h2e, 24'h000193);
    `CHK("calib_active", 1'b1, calib_active)
    `CHK("applied_gain", 3'h3, applied_gain_code)
    `CHK("gain_exp", 4'h3, gain_exp)
    repeat (5) seq.frame(16'h0064, 16'hffce);
    rb(16'h0064, 16'hffce);
    wr(8'h2e, 24'h000183);
    seq.frame(16'h0009, 16'h0009);
    rb(16'h0064, 16'hffce);
    `CHK("elec_leak_i", 24'h000064, elec_leak_i)
    `CHK("calib_active", 1'b0, calib_active)
    // Filtered, time constant 2 frames: seed then halve toward zero
    wr(8'h2e, 24'h1001b0);
    seq.frame(16'h0040, 16'hffc0);
    seq.frame(16'h0000, 16'h0000);
    rb(16'h0020, 16'hffe0);
    repeat (8) seq.frame(16'h0000, 16'h0000);
    // Light calibration, direct sampling, calibrated value in use
    wr(8'h2e, 24'h001200);
    repeat (5) seq.frame(16'h0007, 16'hfffe);
    rb(16'h0007, 16'hfffe);
    wr(8'h2e, 24'h800200);
    `CHK("light_leak_i", 24'h000007, light_leak_i)
    `CHK("light_leak_q", 24'hfffffe, light_leak_q)
    wr(8'h2e, 24'h800400);
    // Raw lines hold a sample only alongside the frame pulse
    fork
      seq.frame(16'h1111, 16'h2222);
    join_none
    repeat (2) @(negedge core_clk);
    `CHK("inphase_readback", 16'h1111, inphase_readback)
    `CHK("quad_readback", 16'h2222, quad_readback)
    wr(8'h2e, 24'h800600);
    seq.frame(16'h0000, 16'h0000);
    rb(16'(seq.frames), 16'h0000);
    wr(8'h2e, 24'h800800);
    rb(16'h0000, 16'h0000);
    give_verdict();
  end
endmodule
